// ==== src/ibh_defs.vh ====
// constants of the inductive button host interface: register offsets,
// field positions, reset values and timing counts
// assumes a single 250 MHz system clock and a register port on two-wire pins
`ifndef IBH_DEFS_VH
`define IBH_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define IBH_OFS_DEVICE_STATUS 8'h00
`define IBH_OFS_DETECT_FLAGS 8'h01
`define IBH_OFS_FORCE_FIRST 8'h02
`define IBH_OFS_FORCE_LAST 8'h09
`define IBH_OFS_CONFIG_CTRL 8'h0A
`define IBH_OFS_CHAN_ENABLE 8'h0C
`define IBH_OFS_SCAN_RATE 8'h0D
`define IBH_OFS_SENS0 8'h0E
`define IBH_OFS_SENS1 8'h10
`define IBH_OFS_INT_POL 8'h11
`define IBH_OFS_SENS2 8'h12
`define IBH_OFS_SENS3 8'h14
`define IBH_OFS_BASE_NP 8'h15
`define IBH_OFS_BASE_LP 8'h16
`define IBH_OFS_POLARITY 8'h1C

// ****************************************
// field positions
// ****************************************
`define IBH_STAT_EVENT_BIT 0
`define IBH_STAT_ERROR_BIT 1
`define IBH_STAT_PERMIT_BIT 2
`define IBH_STAT_CFG_BIT 3
`define IBH_CFG_MODE_BIT 0
`define IBH_INT_POL_BIT 0

// ****************************************
// reset values
// ****************************************
`define IBH_RST_CONFIG_CTRL 8'h00
`define IBH_RST_CHAN_ENABLE 8'h00
`define IBH_RST_SCAN_RATE 8'h01
`define IBH_RST_SENS 8'h28
`define IBH_RST_INT_POL 8'h00
`define IBH_RST_POLARITY 8'h00
`define IBH_RST_BASE 8'h03

// ****************************************
// target addresses, timing and detect threshold
// ****************************************
`define IBH_ADDR_LOW 7'h2A
`define IBH_ADDR_HIGH 7'h2B
`define IBH_CLK_MHZ 250
`define IBH_NP_FAST_PERIOD_US 12500
`define IBH_LP_FAST_PERIOD_US 200000
`define IBH_DETECT_TH 12'h100

`endif

// ==== src/ibh_button_if.v ====
// inductive button host interface: two-wire register target, scan
// sequencer, gain and baseline arithmetic, button and interrupt pins
// assumes scl/sda sampled synchronously and an external converter that
// answers conv_start with conv_done and a 12-bit signed raw value
`timescale 1ns/1ps
`include "ibh_defs.vh"

module ibh_button_if #(
    parameter NCH = 4,
    parameter [31:0] NP_FAST_CYC = `IBH_NP_FAST_PERIOD_US * `IBH_CLK_MHZ,
    parameter [31:0] LP_FAST_CYC = `IBH_LP_FAST_PERIOD_US * `IBH_CLK_MHZ,
    parameter [11:0] DETECT_TH = `IBH_DETECT_TH
) (
    input wire sys_clk,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    input wire addr_select_pin,
    input wire low_power_select_pin,
    output reg conv_start,
    output wire [1:0] conv_channel,
    input wire conv_done,
    input wire [11:0] conv_value,
    input wire conv_error,
    output reg [NCH-1:0] button_pin_n,
    output reg interrupt_request_pin
);

// ****************************************
// state codes
// ****************************************
localparam [3:0] I_IDLE = 4'h0, I_ADDR = 4'h1, I_ACKA = 4'h2, I_PTR = 4'h3,
    I_ACKP = 4'h4, I_WDAT = 4'h5, I_ACKW = 4'h6, I_RDAT = 4'h7, I_RACK = 4'h8;
localparam [2:0] SC_WAIT = 3'h0, SC_FIND = 3'h1, SC_CONV = 3'h2, SC_CALC = 3'h3,
    SC_CFG = 3'h4;

// ****************************************
// gain: mantissa per step of 9%, doubling every 8 codes
// ****************************************
function signed [11:0] gain_scale;
    input signed [12:0] d;
    input [5:0] g;
    reg signed [7:0] m;
    reg signed [31:0] p;
    begin
        case (g[2:0])
            3'h0: m = 8'sh20;
            3'h1: m = 8'sh23;
            3'h2: m = 8'sh26;
            3'h3: m = 8'sh29;
            3'h4: m = 8'sh2D;
            3'h5: m = 8'sh31;
            3'h6: m = 8'sh35;
            default: m = 8'sh3A;
        endcase
        p = d * m;
        p = p <<< g[5:3];
        p = p >>> 5;
        if (p > 32'sh000007FF) gain_scale = 12'sh7FF;
        else if (p < 32'shFFFFF800) gain_scale = 12'sh800;
        else gain_scale = p[11:0];
    end
endfunction

// ****************************************
// registers
// ****************************************
reg [7:0] config_ctrl_reg, channel_enable_reg, scan_rate_reg, int_pol_reg;
reg [7:0] polarity_reg, base_np_reg, base_lp_reg;
reg [7:0] sens_reg [0:3];
reg [3:0] i_state_reg;
reg [3:0] bit_cnt_reg;
reg [7:0] shift_reg, ptr_reg, wr_addr_reg, wr_data_reg;
reg scl_q_reg, sda_q_reg, rw_reg, nack_reg, wr_stb_reg, stat_rd_reg;
reg [2:0] sc_reg;
reg [2:0] idx_reg;
reg [31:0] tmr_reg;
reg [11:0] raw_reg;
reg [11:0] base_reg [0:3];
reg [11:0] force_live_reg [0:3];
reg [11:0] force_snap_reg [0:3];
reg [3:0] det_live_reg, det_snap_reg;
reg event_reg, err_reg, int_pend_reg;
reg [7:0] rd_byte;
integer i;
integer j;

// ****************************************
// derived signals
// ****************************************
wire [3:0] chan_mask = (NCH == 2) ? 4'h3 : 4'hF;
wire cfg_on = config_ctrl_reg[`IBH_CFG_MODE_BIT];
wire lp_mode = ~low_power_select_pin;
wire [3:0] active = channel_enable_reg[3:0] & chan_mask &
    (lp_mode ? channel_enable_reg[7:4] : 4'hF);
wire [1:0] rate_code = lp_mode ? scan_rate_reg[3:2] : scan_rate_reg[1:0];
wire [31:0] period = (lp_mode ? LP_FAST_CYC : NP_FAST_CYC) << (2'h3 - rate_code);
wire boundary = (tmr_reg == 32'h00000000);
wire write_permit_flag = cfg_on && (sc_reg == SC_CFG);
wire [1:0] ch = idx_reg[1:0];
wire signed [12:0] diff = {raw_reg[11], raw_reg} - {base_reg[ch][11], base_reg[ch]};
wire signed [11:0] scaled = gain_scale(diff, sens_reg[ch][5:0]);
wire signed [11:0] negated = (scaled == 12'sh800) ? 12'sh7FF : -scaled;
wire [11:0] force_val = polarity_reg[4 + ch] ? negated : scaled;
wire hit = scaled > $signed(DETECT_TH);
wire [2:0] bl_shift = (lp_mode ? base_lp_reg[2:0] : base_np_reg[2:0]) + 3'h1;
wire signed [12:0] bl_step = diff >>> bl_shift;
wire [12:0] bl_sum = {base_reg[ch][11], base_reg[ch]} + bl_step;
wire press_evt = (sc_reg == SC_CALC) && hit && !det_live_reg[ch];
wire [6:0] my_addr = (NCH == 2 && addr_select_pin) ? `IBH_ADDR_HIGH : `IBH_ADDR_LOW;
wire scl_rise = scl_in & ~scl_q_reg;
wire scl_fall = ~scl_in & scl_q_reg;
wire bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
wire bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
wire [7:0] doff = ptr_reg - `IBH_OFS_FORCE_FIRST;
wire [11:0] snap_word = force_snap_reg[doff[2:1]];

assign sda_out = 1'b0;
assign conv_channel = ch;

// ****************************************
// read multiplexer
// ****************************************
always @* begin
    rd_byte = 8'h00;
    if (ptr_reg == `IBH_OFS_DEVICE_STATUS) begin
        rd_byte[`IBH_STAT_EVENT_BIT] = event_reg;
        rd_byte[`IBH_STAT_ERROR_BIT] = err_reg;
        rd_byte[`IBH_STAT_PERMIT_BIT] = write_permit_flag;
        rd_byte[`IBH_STAT_CFG_BIT] = cfg_on;
    end else if (ptr_reg == `IBH_OFS_DETECT_FLAGS) begin
        rd_byte = {4'h0, det_snap_reg & chan_mask};
    end else if (ptr_reg >= `IBH_OFS_FORCE_FIRST && ptr_reg <= `IBH_OFS_FORCE_LAST) begin
        if (chan_mask[doff[2:1]]) begin
            rd_byte = doff[0] ? {4'h0, snap_word[11:8]} : snap_word[7:0];
        end
    end else begin
        case (ptr_reg)
            `IBH_OFS_CONFIG_CTRL: rd_byte = config_ctrl_reg;
            `IBH_OFS_CHAN_ENABLE: rd_byte = channel_enable_reg;
            `IBH_OFS_SCAN_RATE: rd_byte = scan_rate_reg;
            `IBH_OFS_SENS0: rd_byte = sens_reg[0];
            `IBH_OFS_SENS1: rd_byte = sens_reg[1];
            `IBH_OFS_INT_POL: rd_byte = int_pol_reg;
            `IBH_OFS_SENS2: rd_byte = sens_reg[2];
            `IBH_OFS_SENS3: rd_byte = sens_reg[3];
            `IBH_OFS_BASE_NP: rd_byte = base_np_reg;
            `IBH_OFS_BASE_LP: rd_byte = base_lp_reg;
            `IBH_OFS_POLARITY: rd_byte = polarity_reg;
            default: rd_byte = 8'h00;
        endcase
    end
end

// ****************************************
// two-wire target
// ****************************************
always @(posedge sys_clk) begin
    if (!resetn) begin
        i_state_reg <= I_IDLE;
        bit_cnt_reg <= 4'h0;
        shift_reg <= 8'h00;
        ptr_reg <= 8'h00;
        wr_addr_reg <= 8'h00;
        wr_data_reg <= 8'h00;
        scl_q_reg <= 1'b1;
        sda_q_reg <= 1'b1;
        rw_reg <= 1'b0;
        nack_reg <= 1'b1;
        wr_stb_reg <= 1'b0;
        stat_rd_reg <= 1'b0;
        sda_oe <= 1'b0;
    end else begin
        scl_q_reg <= scl_in;
        sda_q_reg <= sda_in;
        wr_stb_reg <= 1'b0;
        stat_rd_reg <= 1'b0;
        if (bus_start) begin
            i_state_reg <= I_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            i_state_reg <= I_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (i_state_reg == I_ADDR || i_state_reg == I_PTR || i_state_reg == I_WDAT) begin
                shift_reg <= {shift_reg[6:0], sda_in};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (i_state_reg == I_RACK)
                nack_reg <= sda_in;
        end else if (scl_fall) begin
            case (i_state_reg)
                I_ADDR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        if (shift_reg[7:1] == my_addr) begin
                            sda_oe <= 1'b1;
                            rw_reg <= shift_reg[0];
                            i_state_reg <= I_ACKA;
                        end else begin
                            i_state_reg <= I_IDLE;
                        end
                    end
                end
                I_ACKA, I_RACK: begin
                    if (i_state_reg == I_RACK && nack_reg) begin
                        sda_oe <= 1'b0;
                        i_state_reg <= I_IDLE;
                    end else if (rw_reg) begin
                        shift_reg <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bit_cnt_reg <= 4'h1;
                        i_state_reg <= I_RDAT;
                        if (ptr_reg == `IBH_OFS_DEVICE_STATUS)
                            stat_rd_reg <= 1'b1;
                    end else begin
                        sda_oe <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        i_state_reg <= I_PTR;
                    end
                end
                I_PTR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        ptr_reg <= shift_reg;
                        sda_oe <= 1'b1;
                        i_state_reg <= I_ACKP;
                    end
                end
                I_ACKP, I_ACKW: begin
                    sda_oe <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    i_state_reg <= I_WDAT;
                end
                I_WDAT: begin
                    if (bit_cnt_reg == 4'h8) begin
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= shift_reg;
                        wr_stb_reg <= 1'b1;
                        ptr_reg <= ptr_reg + 8'h01;
                        sda_oe <= 1'b1;
                        i_state_reg <= I_ACKW;
                    end
                end
                I_RDAT: begin
                    if (bit_cnt_reg == 4'h8) begin
                        sda_oe <= 1'b0;
                        ptr_reg <= ptr_reg + 8'h01;
                        i_state_reg <= I_RACK;
                    end else begin
                        sda_oe <= ~shift_reg[6];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                default: i_state_reg <= I_IDLE;
            endcase
        end
    end
end

// ****************************************
// configuration registers
// ****************************************
always @(posedge sys_clk) begin
    if (!resetn) begin
        config_ctrl_reg <= `IBH_RST_CONFIG_CTRL;
        channel_enable_reg <= `IBH_RST_CHAN_ENABLE;
        scan_rate_reg <= `IBH_RST_SCAN_RATE;
        int_pol_reg <= `IBH_RST_INT_POL;
        polarity_reg <= `IBH_RST_POLARITY;
        base_np_reg <= `IBH_RST_BASE;
        base_lp_reg <= `IBH_RST_BASE;
        for (i = 0; i < 4; i = i + 1)
            sens_reg[i] <= `IBH_RST_SENS;
    end else if (wr_stb_reg) begin
        case (wr_addr_reg)
            `IBH_OFS_CONFIG_CTRL: config_ctrl_reg <= wr_data_reg;
            `IBH_OFS_CHAN_ENABLE: channel_enable_reg <= wr_data_reg;
            `IBH_OFS_SCAN_RATE: scan_rate_reg <= wr_data_reg;
            `IBH_OFS_SENS0: sens_reg[0] <= wr_data_reg;
            `IBH_OFS_SENS1: sens_reg[1] <= wr_data_reg;
            `IBH_OFS_INT_POL: int_pol_reg <= wr_data_reg;
            `IBH_OFS_SENS2: sens_reg[2] <= wr_data_reg;
            `IBH_OFS_SENS3: sens_reg[3] <= wr_data_reg;
            `IBH_OFS_BASE_NP: base_np_reg <= wr_data_reg;
            `IBH_OFS_BASE_LP: base_lp_reg <= wr_data_reg;
            `IBH_OFS_POLARITY: polarity_reg <= wr_data_reg;
            default: ;
        endcase
    end
end

// ****************************************
// scan sequencer, flags, snapshot and pins
// ****************************************
always @(posedge sys_clk) begin
    if (!resetn) begin
        sc_reg <= SC_WAIT;
        idx_reg <= 3'h0;
        tmr_reg <= 32'h00000000;
        raw_reg <= 12'h000;
        conv_start <= 1'b0;
        det_live_reg <= 4'h0;
        det_snap_reg <= 4'h0;
        event_reg <= 1'b0;
        err_reg <= 1'b0;
        int_pend_reg <= 1'b0;
        button_pin_n <= {NCH{1'b1}};
        interrupt_request_pin <= 1'b1;
        for (j = 0; j < 4; j = j + 1) begin
            base_reg[j] <= 12'h000;
            force_live_reg[j] <= 12'h000;
            force_snap_reg[j] <= 12'h000;
        end
    end else begin
        conv_start <= 1'b0;
        tmr_reg <= boundary ? period - 32'h00000001 : tmr_reg - 32'h00000001;
        // set wins over the status-read clear
        event_reg <= (event_reg & ~stat_rd_reg) | press_evt;
        err_reg <= (err_reg & ~stat_rd_reg) | conv_error;
        int_pend_reg <= (int_pend_reg & ~stat_rd_reg) | press_evt | conv_error;
        if (stat_rd_reg) begin
            det_snap_reg <= det_live_reg;
            for (j = 0; j < 4; j = j + 1)
                force_snap_reg[j] <= force_live_reg[j];
        end
        for (j = 0; j < NCH; j = j + 1)
            button_pin_n[j] <= ~(det_live_reg[j] ^ polarity_reg[j]);
        interrupt_request_pin <= ~(int_pend_reg ^ int_pol_reg[`IBH_INT_POL_BIT]);
        case (sc_reg)
            SC_WAIT: begin
                if (cfg_on) begin
                    sc_reg <= SC_CFG;
                end else if (boundary) begin
                    idx_reg <= 3'h0;
                    sc_reg <= SC_FIND;
                end
            end
            SC_FIND: begin
                if (cfg_on) begin
                    sc_reg <= SC_CFG;
                end else if (idx_reg >= NCH) begin
                    sc_reg <= SC_WAIT;
                end else if (active[ch]) begin
                    conv_start <= 1'b1;
                    sc_reg <= SC_CONV;
                end else begin
                    idx_reg <= idx_reg + 3'h1;
                end
            end
            SC_CONV: begin
                if (conv_done) begin
                    raw_reg <= conv_value;
                    sc_reg <= SC_CALC;
                end
            end
            SC_CALC: begin
                force_live_reg[ch] <= force_val;
                det_live_reg[ch] <= hit;
                if (!hit)
                    base_reg[ch] <= bl_sum[11:0];
                idx_reg <= idx_reg + 3'h1;
                sc_reg <= SC_FIND;
            end
            SC_CFG: begin
                if (!cfg_on) begin
                    idx_reg <= 3'h0;
                    tmr_reg <= period - 32'h00000001;
                    sc_reg <= SC_FIND;
                end
            end
            default: sc_reg <= SC_WAIT;
        endcase
    end
end

endmodule // ibh_button_if

// ==== test/ibh_button_if_props.sv ====
`timescale 1ns/1ps
// port checker for ibh_button_if: bus answer timing, converter handshake
// assumes it is bound to the design with its channel count handed on
module ibh_button_if_props #(
    parameter NCH = 4
) (
    input wire sys_clk,
    input wire resetn,
    input wire scl_in,
    input wire sda_oe,
    input wire conv_start,
    input wire [1:0] conv_channel,
    input wire conv_done,
    input wire [NCH-1:0] button_pin_n,
    input wire interrupt_request_pin
);
    reg pend;
    reg [3:0] low_cnt;

    // request outstanding, and cycles since scl went low
    always @(posedge sys_clk) begin
        if (!resetn) begin
            pend <= 1'b0;
            low_cnt <= 4'h0;
        end else begin
            pend <= conv_start || (pend && !conv_done);
            low_cnt <= scl_in ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_pulse;
        conv_start ##1 !conv_start;
    endsequence
    sequence s_pins_idle;
        button_pin_n == {NCH{1'b1}} && interrupt_request_pin && !sda_oe;
    endsequence

    a_conv_pulse_one: assert property (conv_start |-> s_pulse)
        else $error("conversion request held over one cycle");
    a_conv_chan_range: assert property (conv_start |-> conv_channel < NCH)
        else $error("conversion of a missing channel");
    a_conv_one_pending: assert property (conv_start |-> !pend)
        else $error("second request before the answer");
    a_conv_chan_held: assert property (conv_start |=> $stable(conv_channel))
        else $error("channel index moved during conversion");
    a_reset_pins_idle: assert property ($rose(resetn) |-> s_pins_idle)
        else $error("outputs not idle at reset release");
    a_first_edge_quiet: assert property ($rose(resetn) |=> s_pins_idle ##0 !conv_start)
        else $error("outputs moved on first edge after reset");
    a_oe_after_fall: assert property ($changed(sda_oe) |-> low_cnt inside {[1:3]})
        else $error("data line driver changed away from scl fall");
    a_oe_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data line driver changed while scl high");
endmodule // ibh_button_if_props

// ==== test/ibh_host_model.sv ====
`timescale 1ns/1ps
// two-wire host model: drives scl, pulls sda low, runs register transfers
// assumes the resolved, pulled-up data line is fed back on sda
module ibh_host_model #(
    parameter Q = 8
) (
    input wire sys_clk,
    input wire sda,
    output reg scl = 1'b1,
    output reg sda_low = 1'b0
);
    reg [6:0] tgt = 7'h2A;
    reg [7:0] data_q [0:19];
    reg nak;
    reg junk;
    reg [7:0] junk_b;

    task tick(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask
    task bus_start;
        sda_low = 1'b0;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_low = 1'b1;
        tick(Q);
        scl = 1'b0;
    endtask
    task bus_stop;
        sda_low = 1'b1;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_low = 1'b0;
        tick(Q);
    endtask
    // data set while scl low, sampled just before scl falls
    task clk_bit(input b, output r);
        sda_low = !b;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        r = sda;
        scl = 1'b0;
    endtask
    task xfer(input [7:0] d, input last, output [7:0] r, output a);
        integer i;
        for (i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
        clk_bit(last, a);
    endtask
    task open_ptr(input [7:0] p);
        bus_start;
        xfer({tgt, 1'b0}, 1'b1, junk_b, nak);
        xfer(p, 1'b1, junk_b, nak);
    endtask
    task wr_burst(input [7:0] p, input integer n);
        integer k;
        open_ptr(p);
        for (k = 0; k < n; k++) xfer(data_q[k], 1'b1, junk_b, nak);
        bus_stop;
    endtask
    // nack on the last byte ends the read
    task rd_burst(input [7:0] p, input integer n);
        integer k;
        open_ptr(p);
        bus_start;
        xfer({tgt, 1'b1}, 1'b1, junk_b, nak);
        for (k = 0; k < n; k++) xfer(8'hFF, k == n - 1, data_q[k], junk);
        bus_stop;
    endtask
endmodule // ibh_host_model

// ==== test/ibh_button_if_tb.sv ====
`timescale 1ns/1ps
// bench for the button host interface, four channels, short scan periods,
// plus an idle two-channel variant on the same bus for address select
// assumes the host model on the bus and a converter stand-in here
module ibh_button_if_tb;
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg addr_select_pin = 1'b0;
    reg addr2 = 1'b1;
    reg low_power_select_pin = 1'b1;
    reg conv_done = 1'b0;
    reg [11:0] conv_value = 12'h000;
    reg conv_error = 1'b0;
    reg [2:0] cdly = 3'h0;
    reg [1:0] cch = 2'h0;
    reg [3:0] seen = 4'h0;
    reg [11:0] raw [0:3];
    wire scl;
    wire sda_low;
    wire sda_oe;
    wire conv_start;
    wire [1:0] conv_channel;
    wire [3:0] button_pin_n;
    wire interrupt_request_pin;
    wire sda_out;
    wire sda_oe2;
    wire sda = !(sda_low || (sda_oe && !sda_out) || sda_oe2);
    integer n_fail = 0;
    integer checks = 0;

    // ********
    // clock, converter stand-in, instances
    // ********
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // answers three cycles after each request, garbage otherwise
    always @(negedge sys_clk) begin
        conv_done <= cdly == 3'h1;
        conv_value <= cdly == 3'h1 ? raw[cch] : ~conv_value;
        if (conv_start) begin
            cdly <= 3'h3;
            cch <= conv_channel;
            seen[conv_channel] <= 1'b1;
        end else if (cdly != 3'h0) begin
            cdly <= cdly - 3'h1;
        end
    end
    ibh_button_if #(.NCH(4), .NP_FAST_CYC(64), .LP_FAST_CYC(256)) ibh_button_if_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_select_pin(addr_select_pin),
        .low_power_select_pin(low_power_select_pin),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .conv_done(conv_done),
        .conv_value(conv_value),
        .conv_error(conv_error),
        .button_pin_n(button_pin_n),
        .interrupt_request_pin(interrupt_request_pin)
    );
    // two-channel variant, answering by its select pin, never scanning
    ibh_button_if #(.NCH(2)) ibh_button_if_two_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(),
        .sda_oe(sda_oe2),
        .addr_select_pin(addr2),
        .low_power_select_pin(1'b1),
        .conv_start(),
        .conv_channel(),
        .conv_done(1'b0),
        .conv_value(12'h000),
        .conv_error(1'b0),
        .button_pin_n(),
        .interrupt_request_pin()
    );
    ibh_host_model #(.Q(8)) ibh_host_model_inst (
        .sys_clk(sys_clk),
        .sda(sda),
        .scl(scl),
        .sda_low(sda_low)
    );

    // ********
    // shared tasks
    // ********
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task rd1(input [7:0] p, output [7:0] v);
        ibh_host_model_inst.rd_burst(p, 1);
        v = ibh_host_model_inst.data_q[0];
    endtask
    task wr1(input [7:0] p, input [7:0] d);
        ibh_host_model_inst.data_q[0] = d;
        ibh_host_model_inst.wr_burst(p, 1);
    endtask
    task wait_conv;
        integer k;
        for (k = 0; k < 1000 && conv_start !== 1'b1; k++) @(negedge sys_clk);
        chk("scan restart", conv_start, 1'b1);
        if (conv_start !== 1'b1) final_report;
    endtask
    // enter: set mode and poll permit; leave: clear mode, expect a scan
    task cfg(input on);
        integer k;
        logic [7:0] s;
        wr1(8'h0A, {7'h00, on});
        s = 8'h00;
        for (k = 0; k < 20 && on && s[2] !== 1'b1; k++) rd1(8'h00, s);
        if (on) chk("write permit", s[3:2], 2'b11);
        if (on && s[2] !== 1'b1) final_report;
        if (!on) wait_conv;
    endtask
    task settle;
        repeat (300) @(negedge sys_clk);
        seen = 4'h0;
        repeat (1200) @(negedge sys_clk);
    endtask
    function logic [7:0] cfg_val(input integer k);
        cfg_val = k == 0 ? 8'h05 : k == 1 ? 8'h0F : k == 2 ? 8'h08 : 8'h00;
    endfunction

    // ********
    // scenarios
    // ********
    task t_reset_vals;
        integer k;
        logic [7:0] e;
        chk("idle pins", {button_pin_n, interrupt_request_pin}, 5'h1F);
        ibh_host_model_inst.rd_burst(8'h0A, 19);
        for (k = 10; k < 29; k++) begin
            e = k == 13 ? 8'h01 : (k == 21 || k == 22) ? 8'h03 : 8'h00;
            e = (k >= 14 && k <= 20 && k % 2 == 0 && k != 17) ? 8'h28 : e;
            chk("reset value", ibh_host_model_inst.data_q[k - 10], e);
        end
        $display("reset values done");
    endtask
    task t_config;
        integer k;
        cfg(1'b1);
        for (k = 0; k < 9; k++) ibh_host_model_inst.data_q[k] = cfg_val(k);
        ibh_host_model_inst.wr_burst(8'h0C, 9);
        chk("write ack", ibh_host_model_inst.nak, 1'b0);
        ibh_host_model_inst.rd_burst(8'h0C, 9);
        for (k = 0; k < 9; k++) chk("config", ibh_host_model_inst.data_q[k], cfg_val(k));
        cfg(1'b0);
        $display("config done");
    endtask
    task t_detect;
        settle;
        chk("scanned set", seen, 4'h5);
        chk("pins", {button_pin_n, interrupt_request_pin}, 5'b11100);
        ibh_host_model_inst.rd_burst(8'h00, 4);
        chk("status", ibh_host_model_inst.data_q[0], 8'h01);
        chk("flags", ibh_host_model_inst.data_q[1], 8'h01);
        chk("data", {ibh_host_model_inst.data_q[3], ibh_host_model_inst.data_q[2]}, 16'h0150);
        chk("int cleared", interrupt_request_pin, 1'b1);
        cfg(1'b1);
        settle;
        chk("halted", seen, 4'h0);
        wr1(8'h1C, 8'h11);
        cfg(1'b0);
        settle;
        ibh_host_model_inst.rd_burst(8'h00, 4);
        chk("neg data", {ibh_host_model_inst.data_q[3], ibh_host_model_inst.data_q[2]}, 16'h0EB0);
        chk("pins inverted", button_pin_n, 4'hF);
        $display("detect done");
    endtask
    task pulse_err(input logic e);
        logic [7:0] s;
        @(negedge sys_clk);
        conv_error = 1'b1;
        @(negedge sys_clk);
        conv_error = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("int raised", interrupt_request_pin, e);
        rd1(8'h00, s);
        chk("error flag", s[1], 1'b1);
        chk("int cleared", interrupt_request_pin, !e);
    endtask
    task t_error;
        pulse_err(1'b0);
        cfg(1'b1);
        wr1(8'h11, 8'h01);
        cfg(1'b0);
        pulse_err(1'b1);
        $display("error done");
    endtask
    task t_low_power;
        cfg(1'b1);
        wr1(8'h0C, 8'h15);
        cfg(1'b0);
        low_power_select_pin = 1'b0;
        settle;
        chk("low power set", seen, 4'h1);
        low_power_select_pin = 1'b1;
        settle;
        chk("normal set", seen, 4'h5);
        $display("low power done");
    endtask
    task t_address;
        logic [7:0] s;
        addr_select_pin = 1'b1;
        ibh_host_model_inst.tgt = 7'h2B;
        wr1(8'h0D, 8'h00);
        chk("two-channel high", ibh_host_model_inst.nak, 1'b0);
        ibh_host_model_inst.tgt = 7'h2A;
        rd1(8'h0D, s);
        chk("fixed address", {ibh_host_model_inst.nak, s}, 9'h00F);
        addr2 = 1'b0;
        ibh_host_model_inst.tgt = 7'h2B;
        wr1(8'h0D, 8'h00);
        chk("foreign nack", ibh_host_model_inst.nak, 1'b1);
        $display("address done");
    endtask

    initial begin
        raw[0] = 12'h0A8;
        raw[1] = 12'h7FF;
        raw[2] = 12'h000;
        raw[3] = 12'h7FF;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        t_reset_vals;
        t_config;
        t_detect;
        t_error;
        t_low_power;
        t_address;
        final_report;
    end
endmodule // ibh_button_if_tb

bind ibh_button_if ibh_button_if_props #(.NCH(NCH)) ibh_button_if_props_inst (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_oe(sda_oe),
    .conv_start(conv_start),
    .conv_channel(conv_channel),
    .conv_done(conv_done),
    .button_pin_n(button_pin_n),
    .interrupt_request_pin(interrupt_request_pin)
);
